/* pkg/vmf_pkg.sv */
// package: constants and types of the voltage-monitor fault logic
// Summary of operation
// - a die over-temperature report enters thermal shutdown and sets a flag kept until power-up.
// - thermal shutdown drops both buck enables and pulls every multipurpose pin low at once.
// - pin 1 code: 00 high impedance, 01 general output, 10 error monitor 1 input, 11 reserved.
// - pin 2 code: 00 general output, 01 fault collector 1, 10 sync push-pull out, 11 monitor 3.
// - pin 3 code: 00 general output, 01 fault collector 2, 10 error monitor 2, 11 monitor 4.
// - each of four monitors detects under and over voltage, routable to either power-good pin.
// - each monitor has its own 4-bit under and over threshold code sent to the comparators.
// - threshold codes step half a percent: under 97 down to 89.5, over 103 up to 110.5.
// - under-voltage debounce codes give 5, 15, 30 and 40 us.
// - over-voltage debounce codes give 30, 50, 80 and 125 us.
// - a debounced fault sets a sticky flag that clears only by writing one to it.
// - live under and over status bits follow the present debounced condition.
package vmf_pkg;
  // ==========================================
  // clock and timing
  localparam int CLK_MHZ = 10;
  localparam int UV_DB_US [4] = '{5, 15, 30, 40};
  localparam int OV_DB_US [4] = '{30, 50, 80, 125};
  localparam int CNT_W = 11;
  // ==========================================
  // register offsets
  localparam logic [3:0] A_LIVE = 4'h0;
  localparam logic [3:0] A_STICKY = 4'h1;
  localparam logic [3:0] A_MASK = 4'h2;
  localparam logic [3:0] A_PG1_ROUTE = 4'h3;
  localparam logic [3:0] A_PG2_ROUTE = 4'h4;
  localparam logic [3:0] A_GPO = 4'h5;
  localparam logic [3:0] A_BUCK = 4'h6;
  localparam logic [3:0] A_PINCFG = 4'h7;
  localparam logic [3:0] A_UVTH = 4'h8;
  localparam logic [3:0] A_OVTH = 4'h9;
  localparam logic [3:0] A_DB = 4'hA;
  // ==========================================
  // field layouts and reset values
  // sticky/mask layout: [3:0] uv per channel, [7:4] ov per channel, [8] thermal
  localparam int TSD_BIT = 8;
  localparam logic [8:0] MASK_RST = 9'h1_FF;
  localparam logic [7:0] ROUTE_RST = 8'h0_0;
  localparam logic [2:0] GPO_RST = 3'h0;
  localparam logic [1:0] BUCK_RST = 2'h3;
  localparam logic [15:0] TH_RST = 16'h0_000;
  // ==========================================
  // pin function codes
  typedef enum logic [1:0] {P1_HIZ, P1_GPO, P1_ERRMON, P1_RSVD} vmf_p1_t;
  typedef enum logic [1:0] {P2_GPO, P2_FCCU, P2_SYNC, P2_MON3} vmf_p2_t;
  typedef enum logic [1:0] {P3_GPO, P3_FCCU, P3_ERRMON, P3_MON4} vmf_p3_t;
  typedef enum logic {RUN, THERMAL_OFF} vmf_state_t;
endpackage

/* rtl/vmf_debounce.sv */
// per-comparator debounce filter with selectable hold time
`timescale 1ns/1ns
module vmf_debounce
  import vmf_pkg::*;
#(
  parameter bit IS_OV = 1'b0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic enable,
  input wire logic cmp,
  input wire logic [1:0] db_code,
  output logic fault
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;

  // cycles for the selected time; least times, so round up
  function automatic logic [CNT_W-1:0] db_cycles(input logic ov, input logic [1:0] c);
    int us;
    us = ov ? OV_DB_US[c] : UV_DB_US[c];
    return CNT_W'(us * CLK_MHZ);
  endfunction

  assign limit = db_cycles(IS_OV, db_code);

  // any drop restarts the timer; fault follows the filtered level
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      fault <= 1'b0;
    end else if (!enable || !cmp) begin
      cnt <= '0;
      fault <= 1'b0;
    end else if (cnt < limit - CNT_W'(1)) begin
      cnt <= cnt + CNT_W'(1);
    end else begin
      fault <= 1'b1;
    end
  end
endmodule

/* rtl/vmf_top.sv */
// voltage-monitor and thermal fault logic with register port
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
module vmf_top
  import vmf_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic [1:0] pin1_function_code,
  input wire logic [1:0] pin2_function_code,
  input wire logic [1:0] pin3_function_code,
  input wire logic [NCH-1:0] uv_cmp,
  input wire logic [NCH-1:0] ov_cmp,
  input wire logic tsd_cmp,
  input wire logic [2:0] pin_in,
  input wire logic sync_clk_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  output logic error_monitor_input_1,
  output logic error_monitor_input_2,
  output logic fault_collector_input_1,
  output logic fault_collector_input_2,
  output logic [4*NCH-1:0] undervoltage_threshold_code,
  output logic [4*NCH-1:0] overvoltage_threshold_code,
  output logic integrated_buck_regulator,
  output logic external_fet_buck_controller,
  output logic power_good_output_1_oe,
  output logic power_good_output_2_oe,
  output logic irq
);
  import vmf_pkg::*;

  // enables and register layout are laid out for four channels only
  if (NCH != 4) begin : g_nch_check
    $error("vmf_top serves exactly four monitor channels");
  end

  // ==========================================
  // input synchronisers
  logic [2*NCH+4:0] sy1, sy2;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sy1 <= '0;
      sy2 <= '0;
    end else begin
      sy1 <= {sync_clk_in, tsd_cmp, pin_in, ov_cmp, uv_cmp};
      sy2 <= sy1;
    end
  end
  logic [NCH-1:0] uv_s, ov_s;
  logic tsd_s, sync_s;
  logic [2:0] pin_s;
  assign uv_s = sy2[NCH-1:0];
  assign ov_s = sy2[2*NCH-1:NCH];
  assign pin_s = sy2[2*NCH+2:2*NCH];
  assign tsd_s = sy2[2*NCH+3];
  assign sync_s = sy2[2*NCH+4];

  // ==========================================
  // pin function codes caught after reset release
  vmf_p1_t p1;
  vmf_p2_t p2;
  vmf_p3_t p3;
  logic straps_taken;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p1 <= P1_HIZ;
      p2 <= P2_GPO;
      p3 <= P3_GPO;
      straps_taken <= 1'b0;
    end else if (!straps_taken) begin
      p1 <= vmf_p1_t'(pin1_function_code);
      p2 <= vmf_p2_t'(pin2_function_code);
      p3 <= vmf_p3_t'(pin3_function_code);
      straps_taken <= 1'b1;
    end
  end

  // ==========================================
  // software registers
  logic [NCH-1:0] pg1_route, pg2_route;
  logic [8:0] mask;
  logic [2:0] general_output;
  logic [1:0] buck_en;
  logic [4*NCH-1:0] uvth, ovth;
  logic [15:0] db_word; // [2c+1:2c] uv code in low byte, ov in high byte
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask <= MASK_RST;
      {pg2_route, pg1_route} <= ROUTE_RST;
      general_output <= GPO_RST;
      buck_en <= BUCK_RST;
      uvth <= TH_RST;
      ovth <= TH_RST;
      db_word <= TH_RST;
    end else if (wr) begin
      unique case (addr)
        A_MASK: mask <= wdata[8:0];
        A_PG1_ROUTE: pg1_route <= wdata[NCH-1:0];
        A_PG2_ROUTE: pg2_route <= wdata[NCH-1:0];
        A_GPO: general_output <= wdata[2:0];
        A_BUCK: buck_en <= wdata[1:0];
        A_UVTH: uvth <= wdata;
        A_OVTH: ovth <= wdata;
        A_DB: db_word <= wdata;
        default: ;
      endcase
    end
  end
  // ==========================================
  // debounce filters, one pair per channel
  logic [NCH-1:0] ch_en, uv_live, ov_live;
  // monitors 3 and 4 live only in their pin's monitor function
  assign ch_en = {p3 == P3_MON4, p2 == P2_MON3, 2'b11};
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    vmf_debounce #(.IS_OV(1'b0)) u_uv (
      .mclk(mclk),
      .rst(rst),
      .enable(ch_en[c]),
      .cmp(uv_s[c]),
      .db_code(db_word[2*c+1:2*c]),
      .fault(uv_live[c])
    );
    vmf_debounce #(.IS_OV(1'b1)) u_ov (
      .mclk(mclk),
      .rst(rst),
      .enable(ch_en[c]),
      .cmp(ov_s[c]),
      .db_code(db_word[2*c+9:2*c+8]),
      .fault(ov_live[c])
    );
  end

  // ==========================================
  // thermal shutdown state
  vmf_state_t state;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= RUN;
    end else if (tsd_s) begin
      state <= THERMAL_OFF;
    end
  end

  // ==========================================
  // sticky flags: set wins over a write-one clear
  logic [8:0] sticky, ev;
  logic [8:0] clr;
  assign ev = {tsd_s, ov_live, uv_live};
  assign clr = (wr && addr == A_STICKY) ? wdata[8:0] : 9'h0_00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sticky <= 9'h0_00;
    end else begin
      sticky[7:0] <= (sticky[7:0] & ~clr[7:0] & {ch_en, ch_en}) | ev[7:0];
      // thermal flag is kept until power-up, writes do not clear it
      sticky[TSD_BIT] <= sticky[TSD_BIT] | ev[TSD_BIT];
    end
  end

  // ==========================================
  // outputs, all registered
  logic shut;
  assign shut = (state == THERMAL_OFF) || tsd_s;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
      integrated_buck_regulator <= 1'b0;
      external_fet_buck_controller <= 1'b0;
    end else if (shut) begin
      // no ordered power-down: everything off in one edge
      pin_out <= 3'h0;
      pin_oe <= 3'h7;
      integrated_buck_regulator <= 1'b0;
      external_fet_buck_controller <= 1'b0;
    end else begin
      integrated_buck_regulator <= buck_en[0];
      external_fet_buck_controller <= buck_en[1];
      // open-drain general outputs drive only their low level
      unique case (p1)
        P1_GPO: begin
          pin_out[0] <= 1'b0;
          pin_oe[0] <= !general_output[0];
        end
        default: begin
          pin_out[0] <= 1'b0;
          pin_oe[0] <= 1'b0;
        end
      endcase
      unique case (p2)
        P2_GPO: begin
          pin_out[1] <= 1'b0;
          pin_oe[1] <= !general_output[1];
        end
        P2_SYNC: begin
          pin_out[1] <= sync_s;
          pin_oe[1] <= 1'b1;
        end
        default: begin
          pin_out[1] <= 1'b0;
          pin_oe[1] <= 1'b0;
        end
      endcase
      pin_out[2] <= 1'b0;
      pin_oe[2] <= (p3 == P3_GPO) && !general_output[2];
    end
  end

  // input functions routed from the pins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      error_monitor_input_1 <= 1'b0;
      error_monitor_input_2 <= 1'b0;
      fault_collector_input_1 <= 1'b0;
      fault_collector_input_2 <= 1'b0;
    end else begin
      error_monitor_input_1 <= (p1 == P1_ERRMON) && pin_s[0];
      fault_collector_input_1 <= (p2 == P2_FCCU) && pin_s[1];
      fault_collector_input_2 <= (p3 == P3_FCCU) && pin_s[2];
      error_monitor_input_2 <= (p3 == P3_ERRMON) && pin_s[2];
    end
  end

  // thresholds forwarded; analog side maps code n to 97-0.5n or 103+0.5n percent
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      undervoltage_threshold_code <= TH_RST;
      overvoltage_threshold_code <= TH_RST;
    end else begin
      undervoltage_threshold_code <= uvth;
      overvoltage_threshold_code <= ovth;
    end
  end

  // power-good pulled low while a routed channel shows a live fault
  logic [NCH-1:0] bad;
  assign bad = uv_live | ov_live;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_good_output_1_oe <= 1'b0;
      power_good_output_2_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      power_good_output_1_oe <= |(bad & pg1_route);
      power_good_output_2_oe <= |(bad & pg2_route);
      irq <= |(sticky & ~mask);
    end
  end

  // ==========================================
  // read port: data in the cycle after the strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= 16'h0_000;
    end else if (rd) begin
      unique case (addr)
        A_LIVE: rdata <= {8'h0_0, ov_live, uv_live};
        A_STICKY: rdata <= {7'h0_0, sticky};
        A_MASK: rdata <= {7'h0_0, mask};
        A_PG1_ROUTE: rdata <= {12'h0_00, pg1_route};
        A_PG2_ROUTE: rdata <= {12'h0_00, pg2_route};
        A_GPO: rdata <= {13'h0_000, general_output};
        A_BUCK: rdata <= {14'h0_000, buck_en};
        A_PINCFG: rdata <= {9'h0_00, state == THERMAL_OFF, p3, p2, p1};
        A_UVTH: rdata <= uvth;
        A_OVTH: rdata <= ovth;
        A_DB: rdata <= db_word;
        default: rdata <= 16'h0_000;
      endcase
    end else begin
      rdata <= 16'h0_000;
    end
  end
endmodule

/* test/vmf_top_assertions.sv */
// checker: port-level timing of the fault logic
`timescale 1ns/1ns
module vmf_chk
  import vmf_pkg::*;
#(
  parameter int NCH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [1:0] pin2_function_code,
  input wire logic [1:0] pin3_function_code,
  input wire logic [NCH-1:0] uv_cmp,
  input wire logic tsd_cmp,
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  input wire logic [4*NCH-1:0] undervoltage_threshold_code,
  input wire logic [4*NCH-1:0] overvoltage_threshold_code,
  input wire logic integrated_buck_regulator,
  input wire logic external_fet_buck_controller,
  input wire logic irq
);
  // ==========================================
  // run lengths of channel 0 comparator, saturating
  logic [9:0] hi0;
  logic [9:0] lo0;
  logic rl;
  logic off;
  assign rl = rd && addr == A_LIVE;
  assign off = !integrated_buck_regulator && !external_fet_buck_controller;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hi0 <= 10'h000;
      lo0 <= 10'h000;
    end else begin
      hi0 <= !uv_cmp[0] ? 10'h000 : hi0 + {9'h000, hi0 != 10'h3FF};
      lo0 <= uv_cmp[0] ? 10'h000 : lo0 + {9'h000, lo0 != 10'h3FF};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // assertions
  AST_RD_IDLE: assert property (!rd |=> rdata == 16'h0000)
    else $error("read data outside read slot");
  // the code goes through the register and then the output flop: two edges
  AST_UVTH: assert property (wr && addr == A_UVTH |-> ##2
    undervoltage_threshold_code == $past(wdata, 2)) else $error("uv code not forwarded");
  AST_OVTH: assert property (wr && addr == A_OVTH |-> ##2
    overvoltage_threshold_code == $past(wdata, 2)) else $error("ov code not forwarded");
  AST_LIVE_DROP: assert property (rl && lo0 >= 10'd6 |=> !rdata[0])
    else $error("live bit held after release");
  AST_LIVE_SET: assert property (rl && hi0 >= 10'd410 |=> rdata[0])
    else $error("live bit missing after longest debounce");
  // live and sticky words carry channel status at these positions; mask words hold writable channel bits there, route words only at bits 2 and 3
  AST_CH3_OFF: assert property (rd && (addr == A_LIVE || addr == A_STICKY) &&
    pin2_function_code != 2'b11 |=> !rdata[2] && !rdata[6])
    else $error("channel 3 active without pin");
  AST_CH4_OFF: assert property (rd && (addr == A_LIVE || addr == A_STICKY) &&
    pin3_function_code != 2'b11 |=> !rdata[3] && !rdata[7])
    else $error("channel 4 active without pin");
  AST_TSD_OFF: assert property (tsd_cmp ##1 tsd_cmp |-> ##3
    (off && pin_oe == 3'b111 && pin_out == 3'b000) [*8]) else $error("no thermal stop");
  cover property (rl && hi0 >= 10'd410);
  cover property (tsd_cmp ##1 tsd_cmp);
  cover property ($rose(irq));
endmodule
bind vmf_top vmf_chk #(.NCH(NCH)) u_chk (.mclk(mclk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin2_function_code(pin2_function_code),
  .pin3_function_code(pin3_function_code), .uv_cmp(uv_cmp), .tsd_cmp(tsd_cmp),
  .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq),
  .undervoltage_threshold_code(undervoltage_threshold_code),
  .overvoltage_threshold_code(overvoltage_threshold_code),
  .integrated_buck_regulator(integrated_buck_regulator),
  .external_fet_buck_controller(external_fet_buck_controller));

/* test/vmf_host.sv */
// host model: polls and writes the register port
`timescale 1ns/1ns
module vmf_host (
  input wire logic mclk,
  input wire logic [15:0] rdata,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  // idle bus from time zero
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write; clearing a sticky flag is a write of one
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // polled read; data only valid in the slot after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    // take the data mid-cycle while they stand, then end on a rising edge
    @(negedge mclk);
    v = rdata;
    @(posedge mclk);
  endtask
endmodule

/* test/tb.sv */
// testbench: register port, debounce, interrupt, thermal and pin functions
`timescale 1ns/1ns
module tb;
  import vmf_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] pc = 2'h3;
  logic [7:0] cv = 8'h00;
  logic tsd_cmp = 1'b0;
  logic [2:0] pin_in = 3'h0;
  logic sck = 1'b0;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d, uvth, ovth;
  logic wr, rd, em1, em2, fc1, fc2, ibr, efb, irq, pg1_oe, pg2_oe;
  logic [2:0] pin_out, pin_oe;
  int fails = 0;
  int cmp_count = 0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) sck <= ~sck;
  vmf_top dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pin1_function_code(pc), .pin2_function_code(pc),
    .pin3_function_code(pc), .uv_cmp(cv[3:0]), .ov_cmp(cv[7:4]), .tsd_cmp(tsd_cmp),
    .pin_in(pin_in), .sync_clk_in(sck), .pin_out(pin_out), .pin_oe(pin_oe),
    .error_monitor_input_1(em1), .error_monitor_input_2(em2),
    .fault_collector_input_1(fc1), .fault_collector_input_2(fc2),
    .undervoltage_threshold_code(uvth), .overvoltage_threshold_code(ovth),
    .integrated_buck_regulator(ibr), .external_fet_buck_controller(efb),
    .power_good_output_1_oe(pg1_oe), .power_good_output_2_oe(pg2_oe), .irq(irq));
  vmf_host host (.mclk(mclk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  // ==========================================
  // checking and closing
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("FAIL %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // pin codes are straps, so they only change under reset
  task automatic do_reset(input logic [1:0] c);
    rst <= 1'b1;
    pc <= c;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [3:0] ra [7] = '{A_LIVE, A_STICKY, A_MASK, A_GPO, A_BUCK, A_PINCFG, 4'hF};
    logic [15:0] rv [7] = '{16'h0000, 16'h0000, 16'h01FF, 16'h0000, 16'h0003, 16'h003F,
      16'h0000};
    host.wr_reg(4'hF, 16'hFFFF);
    for (int i = 0; i < 7; i++) begin
      host.rd_reg(ra[i], d);
      chk(d, rv[i]);
    end
    chk({14'h0, ibr, efb}, 16'h0003);
    host.wr_reg(A_UVTH, 16'hF0A5);
    host.wr_reg(A_OVTH, 16'h0F5A);
    host.rd_reg(A_OVTH, d);
    chk(d, 16'h0F5A);
    chk(uvth, 16'hF0A5);
    chk(ovth, 16'h0F5A);
    $display("test reset and thresholds done");
  endtask
  // bit b: 0..3 under, 4..7 over; its debounce field sits at 2b
  task automatic db_check(input int b, input int code);
    int n;
    int t;
    n = (b > 3 ? OV_DB_US[code] : UV_DB_US[code]) * CLK_MHZ;
    host.wr_reg(A_DB, 16'(code) << (2 * b));
    cv[b] <= 1'b1;
    repeat (n - 10) @(posedge mclk);
    cv[b] <= 1'b0;
    repeat (2) @(posedge mclk);
    cv[b] <= 1'b1;
    t = 0;
    d = 16'h0000;
    while (d[b] !== 1'b1 && t < 2000) begin
      host.rd_reg(A_LIVE, d);
      t += 3; // one poll spans three cycles
    end
    if (d[b] !== 1'b1) begin
      chk({15'h0, d[b]}, 16'h0001);
      complete_run();
    end
    chk(16'(t >= n && t <= n + 8), 16'h0001);
    cv[b] <= 1'b0;
    repeat (8) @(posedge mclk);
    host.rd_reg(A_LIVE, d);
    chk(d, 16'h0000);
    host.rd_reg(A_STICKY, d);
    chk(d, 16'h0001 << b);
    host.wr_reg(A_STICKY, 16'h0001 << b);
    host.rd_reg(A_STICKY, d);
    chk(d, 16'h0000);
    $display("test debounce %0d code %0d done", b, code);
  endtask
  task automatic t_irq;
    host.wr_reg(A_DB, 16'h0000);
    cv[0] <= 1'b1;
    repeat (420) @(posedge mclk);
    host.rd_reg(A_LIVE, d);
    chk(d, 16'h0001);
    // power-good pulls low only for channels routed to it
    host.wr_reg(A_PG1_ROUTE, 16'h0001);
    repeat (2) @(posedge mclk);
    chk({14'h0, pg1_oe, pg2_oe}, 16'h0002);
    host.wr_reg(A_PG2_ROUTE, 16'h0001);
    host.wr_reg(A_PG1_ROUTE, 16'h0002);
    repeat (2) @(posedge mclk);
    chk({14'h0, pg1_oe, pg2_oe}, 16'h0001);
    cv[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    chk({13'h0, pg1_oe, pg2_oe, irq}, 16'h0000);
    host.wr_reg(A_MASK, 16'h01FE);
    host.rd_reg(A_MASK, d);
    chk({15'h0, irq}, 16'h0001);
    host.wr_reg(A_MASK, 16'h01FF);
    host.rd_reg(A_MASK, d);
    chk({15'h0, irq}, 16'h0000);
    host.wr_reg(A_MASK, 16'h01FE);
    host.wr_reg(A_STICKY, 16'h0001);
    host.rd_reg(A_STICKY, d);
    chk({d[14:0], irq}, 16'h0000);
    $display("test interrupt done");
  endtask
  // thermal latch must beat later buck writes and flag clears
  task automatic t_thermal;
    host.wr_reg(A_GPO, 16'h0007);
    tsd_cmp <= 1'b1;
    repeat (3) @(posedge mclk);
    tsd_cmp <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({8'h00, ibr, efb, pin_oe, pin_out}, 16'h0038);
    host.wr_reg(A_BUCK, 16'h0003);
    host.wr_reg(A_STICKY, 16'h01FF);
    host.rd_reg(A_STICKY, d);
    chk(d, 16'h0100);
    host.rd_reg(A_PINCFG, d);
    chk(d, 16'h007F);
    chk({8'h00, ibr, efb, pin_oe, pin_out}, 16'h0038);
    $display("test thermal done");
  endtask
  task automatic t_pins;
    logic [2:0] oe_tab [4] = '{3'b110, 3'b001, 3'b010, 3'b000};
    for (int i = 0; i < 4; i++) begin
      do_reset(2'(i));
      pin_in <= 3'b111;
      cv <= 8'h0C;
      repeat (450) @(posedge mclk);
      host.rd_reg(A_LIVE, d);
      chk(d, i == 3 ? 16'h000C : 16'h0000);
      host.rd_reg(A_PINCFG, d);
      chk(d, 16'(i * 21));
      chk({13'h0, pin_oe}, {13'h0, oe_tab[i]});
      chk({12'h0, em1, em2, fc1, fc2}, {12'h0, i == 2, i == 2, i == 1, i == 1});
      // the sync function copies a clock that flips every cycle
      @(negedge mclk);
      d[0] = pin_out[1];
      @(negedge mclk);
      chk({13'h0, pin_out}, {13'h0, 1'b0, i == 2 && !d[0], 1'b0});
      @(posedge mclk);
      cv <= 8'h00;
      pin_in <= 3'b000;
    end
    $display("test pin functions done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    do_reset(2'h3);
    t_reset();
    for (int c = 0; c < 4; c++) begin
      db_check(c, c);
      db_check(c + 4, c);
    end
    t_irq();
    t_thermal();
    t_pins();
    complete_run();
  end
endmodule
